//--- rtl/inact_consts.vh
// Constants for the inactivity detector: register indices, field layout, timing.
// Assumes inclusion by bare name from the design files of this block.
`ifndef INACT_CONSTS_VH
`define INACT_CONSTS_VH

// Printed offsets are register indices; byte address is four times the index
`define INACT_IDX_THR_HIGH 8'h3e
`define INACT_IDX_THR_LOW 8'h3f
`define INACT_IDX_TIME_HIGH 8'h40
`define INACT_IDX_TIME_MID 8'h41
`define INACT_IDX_TIME_LOW 8'h42
`define INACT_IDX_STATUS 8'h50
`define INACT_IDX_CTRL 8'h51

`define INACT_RESET_BYTE 8'h00
`define INACT_THR_HIGH_MASK 8'h07
`define INACT_THR_W 11
`define INACT_TIME_W 24
`define INACT_SAMPLE_W 12
`define INACT_SCALE_SHIFT 4
`define INACT_AXES 3

// Time step per count, in ns, and the clock period in ns
`define INACT_STEP_NS 500000
`define INACT_CLK_NS 100
// 500 us at a 100 ns clock, sized to the tick counter so no bits are dropped
`define INACT_STEP_CYCLES 13'd5000
`define INACT_TICK_W 13

`endif

//--- rtl/inact_axis_mag.v
// Per-axis magnitude stage: absolute value and scaling of one signed sample.
// Assumes the sample is valid on the same clock; output is registered.
`timescale 1ns/1ps
`include "inact_consts.vh"

module inact_axis_mag (
    input wire pclk, // Clock
    input wire presetn, // Async reset, active low
    input wire [`INACT_SAMPLE_W-1:0] sample, // Signed sample
    input wire [`INACT_THR_W-1:0] limit, // Threshold in codes
    output reg below // Magnitude below threshold
);
    wire [`INACT_SAMPLE_W-1:0] mag;
    wire [`INACT_SAMPLE_W+`INACT_SCALE_SHIFT-1:0] scaled;
    wire [`INACT_SAMPLE_W+`INACT_SCALE_SHIFT-1:0] limit_ext;

    // Most negative code has magnitude 2048, which fits as unsigned 12 bits
    assign mag = sample[`INACT_SAMPLE_W-1] ? (~sample + 12'h001) : sample;
    assign scaled = {mag, 4'h0};
    // Threshold kept in raw codes, no unit conversion
    assign limit_ext = {5'h00, limit};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            below <= 1'b0;
        end else begin
            below <= (scaled < limit_ext);
        end
    end
endmodule

//--- rtl/inact_detector.v
// Inactivity detector: APB register slave, per-axis compare, sustained timer.
// Assumes samples arrive from logic on pclk with a one-cycle valid strobe.
`timescale 1ns/1ps
`include "inact_consts.vh"

module inact_detector #(
    parameter [`INACT_TICK_W-1:0] STEP_CYCLES = `INACT_STEP_CYCLES // Cycles per time count
) (
    input wire pclk, // APB clock, 10 MHz
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output wire pready, // APB ready
    output reg [31:0] prdata, // APB read data
    output wire pslverr, // APB error
    input wire sample_valid, // Sample set strobe
    input wire [`INACT_SAMPLE_W-1:0] sample_x, // X axis sample
    input wire [`INACT_SAMPLE_W-1:0] sample_y, // Y axis sample
    input wire [`INACT_SAMPLE_W-1:0] sample_z, // Z axis sample
    output reg still_event, // Inactivity event pulse
    output reg still_state // Inactivity level
);
    reg [7:0] thr_high;
    reg [7:0] thr_low;
    reg [7:0] time_high;
    reg [7:0] time_mid;
    reg [7:0] time_low;
    reg enable;
    reg event_flag;
    reg [`INACT_TICK_W-1:0] tick_cnt;
    reg [`INACT_TIME_W-1:0] quiet_cnt;
    reg valid_d;
    reg [31:0] next_rdata;
    reg addr_ok;

    wire [`INACT_THR_W-1:0] still_level_limit;
    wire [`INACT_TIME_W-1:0] still_duration_required;
    wire [`INACT_AXES-1:0] axis_below;
    wire [`INACT_AXES*`INACT_SAMPLE_W-1:0] samples;
    wire all_below;
    wire wr_en;
    wire rd_en;
    wire [9:0] idx;
    wire step;
    wire reached;

    assign still_level_limit = {thr_high[2:0], thr_low};
    assign still_duration_required = {time_high, time_mid, time_low};

    // APB: zero wait states, unmapped or misaligned accesses answer with pslverr
    assign pready = 1'b1;
    assign idx = paddr[11:2];
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !pwrite;
    assign pslverr = psel && penable && !addr_ok;

    always @* begin
        addr_ok = (paddr[1:0] == 2'b00);
        next_rdata = 32'h0000_0000;
        case (idx)
            {2'b00, `INACT_IDX_THR_HIGH}: next_rdata[7:0] = thr_high & `INACT_THR_HIGH_MASK;
            {2'b00, `INACT_IDX_THR_LOW}: next_rdata[7:0] = thr_low;
            {2'b00, `INACT_IDX_TIME_HIGH}: next_rdata[7:0] = time_high;
            {2'b00, `INACT_IDX_TIME_MID}: next_rdata[7:0] = time_mid;
            {2'b00, `INACT_IDX_TIME_LOW}: next_rdata[7:0] = time_low;
            {2'b00, `INACT_IDX_STATUS}: next_rdata[1:0] = {still_state, event_flag};
            {2'b00, `INACT_IDX_CTRL}: next_rdata[0] = enable;
            default: addr_ok = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_high <= `INACT_RESET_BYTE;
            thr_low <= `INACT_RESET_BYTE;
            time_high <= `INACT_RESET_BYTE;
            time_mid <= `INACT_RESET_BYTE;
            time_low <= `INACT_RESET_BYTE;
            enable <= 1'b0;
        end else if (wr_en) begin
            case (idx)
                {2'b00, `INACT_IDX_THR_HIGH}: thr_high <= pwdata[7:0] & `INACT_THR_HIGH_MASK;
                {2'b00, `INACT_IDX_THR_LOW}: thr_low <= pwdata[7:0];
                {2'b00, `INACT_IDX_TIME_HIGH}: time_high <= pwdata[7:0];
                {2'b00, `INACT_IDX_TIME_MID}: time_mid <= pwdata[7:0];
                {2'b00, `INACT_IDX_TIME_LOW}: time_low <= pwdata[7:0];
                {2'b00, `INACT_IDX_CTRL}: enable <= pwdata[0];
                default: enable <= enable;
            endcase
        end
    end

    // Read data registered in the setup cycle so it is stable in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en && !penable) begin
            prdata <= next_rdata;
        end
    end

    assign samples = {sample_z, sample_y, sample_x};

    genvar g;
    generate
        for (g = 0; g < `INACT_AXES; g = g + 1) begin : axis
            inact_axis_mag u_mag (
                .pclk(pclk),
                .presetn(presetn),
                .sample(samples[g*`INACT_SAMPLE_W +: `INACT_SAMPLE_W]),
                .limit(still_level_limit),
                .below(axis_below[g])
            );
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_d <= 1'b0;
        end else begin
            valid_d <= sample_valid;
        end
    end

    assign all_below = &axis_below;

    // Time base: one step every 500 us, free-running while quiet
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= {`INACT_TICK_W{1'b0}};
        end else if (!enable || (valid_d && !all_below)) begin
            tick_cnt <= {`INACT_TICK_W{1'b0}};
        end else if (tick_cnt == STEP_CYCLES - 1'b1) begin
            tick_cnt <= {`INACT_TICK_W{1'b0}};
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    assign step = (tick_cnt == STEP_CYCLES - 1'b1);
    assign reached = (quiet_cnt >= still_duration_required);

    // Quiet time counter; a zero duration fires on the first quiet sample
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_cnt <= {`INACT_TIME_W{1'b0}};
        end else if (!enable || (valid_d && !all_below)) begin
            quiet_cnt <= {`INACT_TIME_W{1'b0}};
        end else if (step && !reached) begin
            quiet_cnt <= quiet_cnt + 1'b1;
        end
    end

    // Event pulse on entering the still state; flag is sticky, write 1 clears
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            still_state <= 1'b0;
            still_event <= 1'b0;
            event_flag <= 1'b0;
        end else begin
            still_event <= 1'b0;
            if (!enable || (valid_d && !all_below)) begin
                still_state <= 1'b0;
            end else if (valid_d && all_below && reached && !still_state) begin
                still_state <= 1'b1;
                still_event <= 1'b1;
            end
            // Set wins over a simultaneous clear
            if (enable && valid_d && all_below && reached && !still_state) begin
                event_flag <= 1'b1;
            end else if (wr_en && idx == {2'b00, `INACT_IDX_STATUS} && pwdata[0]) begin
                event_flag <= 1'b0;
            end
        end
    end
endmodule

//--- verification/inact_detector_chk.sv
// Port checker for the inactivity detector: register reads and event timing.
// Assumes one pclk domain and the zero-wait APB slave of the design.
`timescale 1ns/1ps
module inact_detector_chk (
    input wire pclk, // Clock
    input wire presetn, // Reset
    input wire psel, // Select
    input wire penable, // Enable
    input wire pwrite, // Direction
    input wire [11:0] paddr, // Address
    input wire [31:0] prdata, // Read data
    input wire pslverr, // Error
    input wire sample_valid, // Strobe
    input wire still_event, // Event
    input wire still_state // Level
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence rd_acc;
        psel && penable && !pwrite;
    endsequence
    a_thr_reserved: assert property (rd_acc ##0 paddr == 12'h0f8 |-> prdata[31:3] == 29'h0)
        else $error("reserved threshold bits set");
    a_read_byte: assert property (rd_acc |-> prdata[31:8] == 24'h0)
        else $error("read data above byte");
    a_map_hole: assert property (psel && penable && paddr == 12'h0f4 |-> pslverr)
        else $error("hole not refused");
    a_event_pulse: assert property (still_event |=> !still_event)
        else $error("event longer than one cycle");
    a_event_state: assert property (still_event |-> ##[0:1] still_state)
        else $error("event without level");
    a_state_rise: assert property ($rose(still_state) |-> still_event || $past(still_event))
        else $error("level rose without event");
    a_event_cause: assert property (still_event |->
        $past(sample_valid) || $past(sample_valid, 2) || $past(sample_valid, 3))
        else $error("event without sample");
    a_fall_cause: assert property ($fell(still_state) |-> $past(sample_valid, 2) ||
        $past(sample_valid, 3) || $past(psel) || $past(psel, 2))
        else $error("level fell without cause");
endmodule
bind inact_detector inact_detector_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pslverr, .sample_valid, .still_event, .still_state);

//--- verification/inact_detector_tb_top.sv
// Testbench for the inactivity detector: APB register and detection tests.
// Assumes the bound checker; the time step is shortened to 4 cycles.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error at %0t got %h exp %h", $time, (a), (b)); end end
module inact_detector_tb_top;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sample_valid = 0;
    reg [11:0] paddr = 0, sx = 0, sy = 0, sz = 0;
    reg [31:0] pwdata = 0, rd;
    reg er;
    wire pready, pslverr, still_event, still_state;
    wire [31:0] prdata;
    int error_cnt = 0, checks_done = 0, ev_cnt = 0;
    bit [11:0] regs [5] = '{12'h0f8, 12'h0fc, 12'h100, 12'h104, 12'h108};
    bit [7:0] cfg [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h03};
    inact_detector #(.STEP_CYCLES(13'd4)) u_inact_detector (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .sample_valid, .sample_x(sx),
        .sample_y(sy), .sample_z(sz), .still_event, .still_state);
    initial forever #50 pclk = ~pclk;
    always @(posedge pclk) if (still_event === 1'b1) ev_cnt <= ev_cnt + 1;
    task automatic xfer(input bit w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic samp(input [11:0] x, y, z);
        @(posedge pclk);
        sample_valid <= 1;
        sx <= x;
        sy <= y;
        sz <= z;
        @(posedge pclk);
        sample_valid <= 0;
    endtask
    task wrap_up;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        foreach (regs[i]) begin
            xfer(0, regs[i], 0);
            `CHK(rd, 32'h0000_0000)
            xfer(1, regs[i], 32'h0000_005a + i);
        end
        foreach (regs[i]) begin
            xfer(0, regs[i], 0);
            `CHK(rd, (i == 0) ? 32'h0000_0002 : 32'h0000_005a + i)
            xfer(1, regs[i], {24'h0, cfg[i]});
        end
        xfer(1, 12'h0f4, 32'h0000_0001);
        `CHK(er, 1'b1)
        xfer(0, 12'h0f4, 0);
        `CHK(rd, 32'h0000_0000)
        xfer(1, 12'h144, 32'h0000_0001);
        // Threshold 256 codes: 15 stays quiet, 16 is loud after the shift by four
        samp(12'h010, 0, 0);
        samp(0, 12'hff1, 12'h00f);
        repeat (5) @(posedge pclk);
        samp(0, 0, 0);
        repeat (4) @(posedge pclk);
        `CHK(ev_cnt, 0)
        repeat (20) @(posedge pclk);
        samp(0, 12'hff0, 0);
        samp(0, 0, 0);
        repeat (4) @(posedge pclk);
        `CHK(ev_cnt, 0)
        repeat (20) @(posedge pclk);
        samp(12'h00f, 12'hff1, 12'h001);
        repeat (4) @(posedge pclk);
        `CHK(ev_cnt, 1)
        xfer(0, 12'h140, 0);
        `CHK(rd, 32'h0000_0003)
        samp(0, 0, 12'h010);
        repeat (4) @(posedge pclk);
        `CHK(still_state, 1'b0)
        xfer(1, 12'h140, 32'h0000_0001);
        xfer(0, 12'h140, 0);
        `CHK(rd, 32'h0000_0000)
        wrap_up();
    end
    initial begin
        #(2000 * 100);
        error_cnt++;
        wrap_up();
    end
endmodule
